// [verilog/power_switch_fault_sequencer.sv]
// Fault sequencer for a high-side gate driver with an APB register port.
// Assumes comparator results and control pins arrive asynchronously and are
// synchronised here; timer thresholds come from analog comparators.
//
// Overview of operation
// - Sense above warning set point starts fast timer charge.
// - Timer at flag level drives current fault flag low.
// - Timer at trip level turns main gate off, then retry starts.
// - Retry alternates slow sink to low level, slow source to trip level.
// - After 32 retry cycles gate returns on and current flag releases.
// - Overcurrent ending before trip keeps gate on and discharges timer.
// - Latch-off configuration keeps gate off after fault until latch reset.
// - Drive low or enable low clears latch, counter, discharges timer.
// - After latch reset, gate pull-up follows next drive high.
// - Short circuit pulls gate low and asserts current flag together.
// - After short circuit, same retry or latch as overcurrent.
// - Enable high gives active mode with pump, drivers, protections on.
// - Enable low gives shutdown: pump, drivers, protections off, gates sunk.
// - Non-precharge variant at 150 C sinks gate, asserts thermal flag.
// - Non-precharge variant at 130 C waits 512 ms, then releases.
// - Precharge variant over-temperature latches both gates off until shutdown or simple driver configuration.
// - Drive input low holds main gate sink active.
// - Simple driver configuration disables all protections.
// - High-side sensing waits for gate good before using short comparator.
// - Precharge input low sinks the precharge gate.
`timescale 1ns/1ps
`default_nettype none
module power_switch_fault_sequencer
#(
   parameter int THERM_RETRY = fault_seq_pkg::THERM_RETRY_CYC
)
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire fault_seq_pkg::pin_in_s pins,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fault_seq_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   output fault_seq_pkg::gate_s gates,
   output fault_seq_pkg::tmr_s timer,
   output logic current_fault_flag_n,
   output logic thermal_fault_flag_n
);
   import fault_seq_pkg::*;

   typedef struct packed {
      pin_in_s sync1;
      pin_in_s sync2;
      cfg_s cfg;
      cur_e cur;
      therm_e therm;
      logic [5:0] retry_cnt;
      logic [24:0] tcnt;
      gate_s gates;
      tmr_s timer;
      logic cur_flag_n;
      logic therm_flag_n;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } st_s;

   localparam st_s ST_RST = '{cur: C_IDLE, therm: T_OK, cfg: CFG_RESET,
      gates: '{main_gate_sink: 1'b1, pre_gate_sink: 1'b1, default: 1'b0},
      cur_flag_n: 1'b1, therm_flag_n: 1'b1, default: '0};
   localparam logic [24:0] THERM_LAST = 25'(THERM_RETRY - 1);

   st_s st;
   st_s next_st;
   pin_in_s s;
   logic active;
   logic prot;
   logic sc;
   logic main_on;
   logic pre_on;
   cur_e fault_dest;

   // Only the second synchroniser stage is ever looked at.
   assign s = st.sync2;
   assign active = s.enable_level_in;
   assign prot = ~st.cfg.simple_drv;

   always_comb
   begin
      next_st = st;
      next_st.sync1 = pins;
      next_st.sync2 = st.sync1;
      // Register access: one wait state, answer registered with pready.
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
      next_st.prdata = 32'h0000_0000;
      if (psel && penable && !st.pready)
      begin
         next_st.pready = 1'b1;
         case (paddr)
            REG_CTRL: next_st.prdata = {28'h000_0000, st.cfg};
            REG_STAT: next_st.prdata = {18'h0_0000, st.therm, st.cur, st.retry_cnt,
               st.cur_flag_n, st.therm_flag_n, st.gates.main_gate_source};
            default: next_st.pslverr = 1'b1;
         endcase
      end
      if (psel && penable && st.pready && pwrite && paddr == REG_CTRL)
      begin
         next_st.cfg = cfg_s'(pwdata[CFG_W-1:0]);
      end
      // A short is believed only once the gate is enhanced in high-side sensing.
      sc = s.short_lvl && (!st.cfg.hs_sense || s.gate_good) && st.gates.main_gate_source;
      fault_dest = st.cfg.latch_off ? C_LATCHED : C_RETRY_DIS;
      if (!active)
      begin
         // Shutdown clears every fault state, including both latches.
         next_st.cur = C_IDLE;
         next_st.therm = T_OK;
         next_st.retry_cnt = 6'h00;
         next_st.tcnt = 25'h000_0000;
      end
      else if (!prot)
      begin
         next_st.cur = C_IDLE;
         next_st.therm = T_OK;
         next_st.retry_cnt = 6'h00;
         next_st.tcnt = 25'h000_0000;
      end
      else
      begin
         case (st.cur)
            C_IDLE:
            begin
               if (sc)
               begin
                  next_st.cur = fault_dest;
               end
               else if (s.warn_lvl && st.gates.main_gate_source)
               begin
                  next_st.cur = C_CHARGE;
               end
            end
            C_CHARGE:
            begin
               if (sc || s.tmr_trip)
               begin
                  next_st.cur = fault_dest;
               end
               else if (!s.warn_lvl)
               begin
                  next_st.cur = C_IDLE;
               end
            end
            C_RETRY_DIS:
            begin
               if (s.tmr_low)
               begin
                  next_st.cur = C_RETRY_CHG;
               end
            end
            C_RETRY_CHG:
            begin
               if (s.tmr_trip)
               begin
                  if (st.retry_cnt == RETRY_LAST)
                  begin
                     next_st.cur = C_IDLE;
                     next_st.retry_cnt = 6'h00;
                  end
                  else
                  begin
                     next_st.cur = C_RETRY_DIS;
                     next_st.retry_cnt = st.retry_cnt + 6'h01;
                  end
               end
            end
            C_LATCHED:
            begin
               if (!s.drive_control_in)
               begin
                  next_st.cur = C_IDLE;
                  next_st.retry_cnt = 6'h00;
               end
            end
            default: next_st.cur = C_IDLE;
         endcase
         case (st.therm)
            T_OK:
            begin
               if (s.temp_hot)
               begin
                  next_st.therm = st.cfg.precharge_var ? T_LATCHED : T_HOT;
               end
            end
            T_HOT:
            begin
               if (s.temp_cool)
               begin
                  next_st.therm = T_RETRY;
                  next_st.tcnt = 25'h000_0000;
               end
            end
            T_RETRY:
            begin
               if (s.temp_hot)
               begin
                  next_st.therm = T_HOT;
               end
               else if (st.tcnt == THERM_LAST)
               begin
                  next_st.therm = T_OK;
               end
               else
               begin
                  next_st.tcnt = st.tcnt + 25'h000_0001;
               end
            end
            T_LATCHED: next_st.therm = T_LATCHED;
            default: next_st.therm = T_OK;
         endcase
      end
      // Fault states override the drive input; the gate follows the next state.
      main_on = active && s.drive_control_in && next_st.therm == T_OK &&
         (next_st.cur == C_IDLE || next_st.cur == C_CHARGE);
      pre_on = active && st.cfg.precharge_var && s.precharge_control_in &&
         next_st.therm != T_LATCHED;
      next_st.gates.main_gate_source = main_on;
      next_st.gates.main_gate_sink = !main_on;
      next_st.gates.pre_gate_source = pre_on;
      next_st.gates.pre_gate_sink = !pre_on;
      next_st.gates.charge_pump_en = active;
      next_st.timer.chg_fast = next_st.cur == C_CHARGE;
      next_st.timer.chg_slow = next_st.cur == C_RETRY_CHG;
      next_st.timer.sink_slow = next_st.cur == C_RETRY_DIS;
      next_st.timer.dis_sw = next_st.cur == C_IDLE;
      next_st.cur_flag_n = !(next_st.cur == C_RETRY_DIS || next_st.cur == C_RETRY_CHG ||
         next_st.cur == C_LATCHED || (next_st.cur == C_CHARGE && s.tmr_flag));
      next_st.therm_flag_n = next_st.therm == T_OK;
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st <= ST_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign prdata = st.prdata;
   assign gates = st.gates;
   assign timer = st.timer;
   assign current_fault_flag_n = st.cur_flag_n;
   assign thermal_fault_flag_n = st.therm_flag_n;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);

   AST_WARN_CHARGE: assert property (
      st.cur == C_IDLE && active && prot && s.warn_lvl && gates.main_gate_source && !sc
      |=> timer.chg_fast && !timer.dis_sw)
      else $error("warning did not start fast timer charge");
   AST_FLAG_WARN: assert property (
      st.cur == C_CHARGE && active && prot && s.warn_lvl && s.tmr_flag
      |=> !current_fault_flag_n)
      else $error("current flag not asserted at timer flag level");
   AST_TRIP_OFF: assert property (
      st.cur == C_CHARGE && active && prot && s.tmr_trip && !st.cfg.latch_off
      |=> gates.main_gate_sink && !gates.main_gate_source && timer.sink_slow)
      else $error("trip did not turn gate off into retry");
   AST_RETRY_ALT: assert property (
      st.cur == C_RETRY_DIS && active && prot && s.tmr_low
      |=> timer.chg_slow && !timer.sink_slow ##0 gates.main_gate_sink)
      else $error("retry did not switch to slow charge");
   AST_RETRY_END: assert property (
      st.cur == C_RETRY_CHG && active && prot && s.tmr_trip && st.retry_cnt == RETRY_LAST
      |=> current_fault_flag_n && st.retry_cnt == 6'h00 && st.cur == C_IDLE)
      else $error("retry did not end after 32 cycles");
   AST_OC_CLEAR: assert property (
      st.cur == C_CHARGE && active && prot && !s.warn_lvl && !s.tmr_trip && !sc
      |=> timer.dis_sw && current_fault_flag_n)
      else $error("short overcurrent not discharged");
   AST_LATCH_CLR: assert property (
      st.cur == C_LATCHED && active && prot && !s.drive_control_in
      |=> timer.dis_sw && st.retry_cnt == 6'h00 ##1 (st.cur == C_IDLE))
      else $error("latch not cleared on drive low");
   AST_SHORT: assert property (
      s.short_lvl && (!st.cfg.hs_sense || s.gate_good) && active && prot && gates.main_gate_source
      |=> gates.main_gate_sink && !current_fault_flag_n)
      else $error("short circuit not acted on");
   AST_SHUTDOWN: assert property (
      !active |=> gates.main_gate_sink && gates.pre_gate_sink && !gates.charge_pump_en
      && current_fault_flag_n)
      else $error("shutdown did not turn everything off");
   AST_THERM_HOT: assert property (
      st.therm == T_OK && active && prot && s.temp_hot && !st.cfg.precharge_var
      |=> !thermal_fault_flag_n && gates.main_gate_sink)
      else $error("over-temperature not acted on");
   AST_DRIVE_LOW: assert property (
      !s.drive_control_in |=> gates.main_gate_sink && !gates.main_gate_source)
      else $error("gate not sunk with drive low");
   AST_PRE_LOW: assert property (
      !s.precharge_control_in |=> gates.pre_gate_sink)
      else $error("precharge gate not sunk");
   AST_HS_WAIT: assert property (
      st.cur == C_IDLE && active && prot && st.cfg.hs_sense && !s.gate_good && s.short_lvl && !s.warn_lvl
      |=> st.cur == C_IDLE && current_fault_flag_n)
      else $error("short acted on before gate was enhanced");
   AST_SHORT_LATCH: assert property (
      s.short_lvl && !st.cfg.hs_sense && st.cfg.latch_off && active && prot && gates.main_gate_source
      |=> st.cur == C_LATCHED && gates.main_gate_sink)
      else $error("short did not latch off");
   AST_LATCH_HOLD: assert property (
      st.cur == C_LATCHED && active && prot && s.drive_control_in
      |=> st.cur == C_LATCHED && gates.main_gate_sink)
      else $error("latched fault released without drive low");
   AST_RETRY_TURN: assert property (
      st.cur == C_RETRY_CHG && active && prot && s.tmr_trip && st.retry_cnt != RETRY_LAST
      |=> timer.sink_slow && st.retry_cnt == $past(st.retry_cnt) + 6'h01)
      else $error("retry charge did not turn into counted discharge");
   AST_SIMPLE: assert property (
      active && !prot
      |=> st.cur == C_IDLE && st.therm == T_OK && current_fault_flag_n && thermal_fault_flag_n)
      else $error("protection active in simple driver configuration");
   AST_PRE_HOT: assert property (
      st.therm == T_OK && active && prot && s.temp_hot && st.cfg.precharge_var
      |=> gates.pre_gate_sink && gates.main_gate_sink && !thermal_fault_flag_n)
      else $error("over-temperature did not sink both gates");
   AST_THERM_LATCH: assert property (
      st.therm == T_LATCHED && active && prot
      |=> st.therm == T_LATCHED && gates.main_gate_sink && gates.pre_gate_sink)
      else $error("thermal latch released while enabled");
   AST_ACTIVE: assert property (
      active |=> gates.charge_pump_en)
      else $error("charge pump off in active mode");

   CV_RETRY_DONE: cover property (st.cur == C_RETRY_CHG ##1 st.cur == C_IDLE);
   CV_LATCHED: cover property (st.cur == C_LATCHED ##1 st.cur == C_IDLE);
   CV_THERM_RETRY: cover property (st.therm == T_RETRY ##1 st.therm == T_OK);
   CV_SHORT_RETRY: cover property (st.cur == C_IDLE ##1 st.cur == C_RETRY_DIS);
   CV_THERM_LATCH: cover property (st.therm == T_OK ##1 st.therm == T_LATCHED);
endmodule : power_switch_fault_sequencer
`default_nettype wire

// [verilog/fault_seq_pkg.sv]
// Package for the power switch fault sequencer: constants, modes and carriers.
// Assumes a single 40 MHz clock and digital comparator results from the analog front end.
package fault_seq_pkg;
   localparam int CLK_FREQ_HZ = 40_000_000;
   localparam int THERM_RETRY_MS = 512;
   localparam int THERM_RETRY_CYC = THERM_RETRY_MS * (CLK_FREQ_HZ / 1000);
   localparam int RETRY_CYCLES = 32;
   localparam logic [5:0] RETRY_LAST = 6'(RETRY_CYCLES - 1);
   localparam int APB_AW = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam int CFG_W = 4;
   localparam logic [3:0] CFG_RESET = 4'h0;

   typedef enum logic [2:0] {C_IDLE, C_CHARGE, C_RETRY_DIS, C_RETRY_CHG, C_LATCHED} cur_e;
   typedef enum logic [1:0] {T_OK, T_HOT, T_RETRY, T_LATCHED} therm_e;

   typedef struct packed {
      logic hs_sense;
      logic simple_drv;
      logic latch_off;
      logic precharge_var;
   } cfg_s;

   typedef struct packed {
      logic drive_control_in;
      logic precharge_control_in;
      logic enable_level_in;
      logic warn_lvl;
      logic short_lvl;
      logic gate_good;
      logic tmr_flag;
      logic tmr_trip;
      logic tmr_low;
      logic temp_hot;
      logic temp_cool;
   } pin_in_s;

   typedef struct packed {
      logic main_gate_source;
      logic main_gate_sink;
      logic pre_gate_source;
      logic pre_gate_sink;
      logic charge_pump_en;
   } gate_s;

   typedef struct packed {
      logic chg_fast;
      logic chg_slow;
      logic sink_slow;
      logic dis_sw;
   } tmr_s;
endpackage : fault_seq_pkg

// [verif/timer_node_model.sv]
// Behavioural timer capacitor outside the sequencer: integrates the source and sink enables.
// Assumes one enable at a time and reports the three comparator levels as the analog side would.
`timescale 1ns/1ps
`default_nettype none
module timer_node_model
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire fault_seq_pkg::tmr_s timer,
   output logic tmr_flag,
   output logic tmr_trip,
   output logic tmr_low
);
   import fault_seq_pkg::*;
   int level;
   // The fast source is four times the slow one, so a trip takes far fewer cycles than a retry phase.
   always_ff @(posedge mclk or negedge arst_n)
      if (!arst_n)
         level <= 0;
      else if (timer.dis_sw)
         level <= 0;
      else if (timer.chg_fast)
         level <= (level > 56) ? 64 : level + 8;
      else if (timer.chg_slow)
         level <= (level > 62) ? 64 : level + 2;
      else if (timer.sink_slow)
         level <= (level < 2) ? 0 : level - 2;
   assign tmr_flag = (level >= 40);
   assign tmr_trip = (level >= 60);
   assign tmr_low = (level <= 2);
endmodule : timer_node_model
`default_nettype wire

// [verif/power_switch_fault_sequencer_test.sv]
// Bench for the fault sequencer: APB, overcurrent retry, latch-off, modes, thermal, precharge.
// Assumes the timer node model closes the loop from the timer enables back to the levels.
`timescale 1ns/1ps
`default_nettype none
module power_switch_fault_sequencer_test;
   import fault_seq_pkg::*;
   localparam int TR = 16;
   logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, er, sk_q;
   logic drv, pre, en, warn, shrt, hot, cool, gg, tf, tt, tl, cflag_n, tflag_n;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   pin_in_s pins;
   gate_s gates;
   tmr_s timer;
   int bad_count, comparisons, cycles, t0, sinks;
   assign pins = {drv, pre, en, warn, shrt, gg, tf, tt, tl, hot, cool};
   power_switch_fault_sequencer #(.THERM_RETRY(TR)) power_switch_fault_sequencer_i (.mclk(mclk),
      .arst_n(arst_n), .pins(pins), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .gates(gates), .timer(timer),
      .current_fault_flag_n(cflag_n), .thermal_fault_flag_n(tflag_n));
   timer_node_model timer_node_model_i (.mclk(mclk), .arst_n(arst_n), .timer(timer), .tmr_flag(tf),
      .tmr_trip(tt), .tmr_low(tl));
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Counting entries into the slow discharge shows the number of retry cycles exactly.
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      sinks <= sinks + int'(timer.sink_slow && !sk_q);
      sk_q <= timer.sink_slow;
      if (cycles == 30000)
      begin
         bad_count++;
         print_verdict;
      end
   end
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic cond(input int k);
      case (k)
         0: return gates.main_gate_source;
         1: return gates.main_gate_sink;
         2: return cflag_n;
         3: return tflag_n;
         4: return timer.chg_fast;
         5: return timer.sink_slow;
         6: return gates.charge_pump_en;
         7: return gates.pre_gate_source;
         9: return timer.chg_slow;
         10: return gates.pre_gate_sink;
         default: return timer.dis_sw;
      endcase
   endfunction : cond
   task automatic wait_c(input int k, input logic v);
      int n;
      n = 0;
      while (cond(k) !== v && n < 4000)
      begin
         @(posedge mclk);
         n++;
      end
      chk(32'(cond(k)), 32'(v));
   endtask : wait_c
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic test_apb;
      apb(1'b0, 8'h00, 32'h0, rd, er);
      chk(rd, 32'h0);
      apb(1'b1, 8'h00, 32'h2, rd, er);
      apb(1'b0, 8'h00, 32'h0, rd, er);
      chk(rd, 32'h2);
      apb(1'b0, 8'h08, 32'h0, rd, er);
      chk({rd[30:0], er}, 32'h1);
      apb(1'b1, 8'h00, 32'h0, rd, er);
   endtask : test_apb
   task automatic test_oc;
      @(posedge mclk);
      warn <= 1'b1;
      wait_c(4, 1'b1);
      @(posedge mclk);
      warn <= 1'b0;
      wait_c(8, 1'b1);
      wait_c(0, 1'b1);
      @(posedge mclk);
      warn <= 1'b1;
      t0 = sinks;
      wait_c(2, 1'b0);
      wait_c(0, 1'b1);
      wait_c(1, 1'b1);
      wait_c(5, 1'b1);
      wait_c(9, 1'b1);
      @(posedge mclk);
      warn <= 1'b0;
      wait_c(0, 1'b1);
      wait_c(2, 1'b1);
      chk(32'(sinks - t0), 32'd32);
      apb(1'b0, 8'h04, 32'h0, rd, er);
      chk(rd, 32'h0000_0007);
   endtask : test_oc
   task automatic test_hs;
      apb(1'b1, 8'h00, 32'h8, rd, er);
      @(posedge mclk);
      gg <= 1'b0;
      shrt <= 1'b1;
      repeat (20) @(posedge mclk);
      wait_c(0, 1'b1);
      wait_c(2, 1'b1);
      t0 = sinks;
      gg <= 1'b1;
      wait_c(1, 1'b1);
      wait_c(2, 1'b0);
      @(posedge mclk);
      shrt <= 1'b0;
      wait_c(0, 1'b1);
      chk(32'(sinks - t0), 32'h20);
   endtask : test_hs
   task automatic test_latch;
      apb(1'b1, 8'h00, 32'h2, rd, er);
      @(posedge mclk);
      shrt <= 1'b1;
      t0 = cycles;
      wait_c(1, 1'b1);
      chk(32'(cycles - t0 <= 6), 32'h1);
      wait_c(2, 1'b0);
      @(posedge mclk);
      shrt <= 1'b0;
      repeat (200) @(posedge mclk);
      wait_c(0, 1'b0);
      drv <= 1'b0;
      wait_c(8, 1'b1);
      wait_c(1, 1'b1);
      @(posedge mclk);
      drv <= 1'b1;
      wait_c(0, 1'b1);
      wait_c(2, 1'b1);
   endtask : test_latch
   task automatic test_mode;
      apb(1'b1, 8'h00, 32'h4, rd, er);
      @(posedge mclk);
      shrt <= 1'b1;
      hot <= 1'b1;
      repeat (100) @(posedge mclk);
      wait_c(0, 1'b1);
      wait_c(3, 1'b1);
      shrt <= 1'b0;
      hot <= 1'b0;
      repeat (5) @(posedge mclk);
      apb(1'b1, 8'h00, 32'h0, rd, er);
      en <= 1'b0;
      wait_c(6, 1'b0);
      wait_c(1, 1'b1);
      @(posedge mclk);
      en <= 1'b1;
      wait_c(6, 1'b1);
      wait_c(0, 1'b1);
   endtask : test_mode
   task automatic test_therm;
      @(posedge mclk);
      hot <= 1'b1;
      cool <= 1'b0;
      wait_c(3, 1'b0);
      wait_c(1, 1'b1);
      @(posedge mclk);
      hot <= 1'b0;
      cool <= 1'b1;
      t0 = cycles;
      wait_c(3, 1'b1);
      chk(32'(cycles - t0 >= TR), 32'h1);
      wait_c(0, 1'b1);
   endtask : test_therm
   task automatic test_pre;
      apb(1'b1, 8'h00, 32'h1, rd, er);
      @(posedge mclk);
      pre <= 1'b1;
      wait_c(7, 1'b1);
      @(posedge mclk);
      pre <= 1'b0;
      wait_c(7, 1'b0);
      @(posedge mclk);
      pre <= 1'b1;
      hot <= 1'b1;
      wait_c(0, 1'b0);
      @(posedge mclk);
      hot <= 1'b0;
      repeat (40) @(posedge mclk);
      wait_c(7, 1'b0);
      wait_c(10, 1'b1);
   endtask : test_pre
   initial
   begin
      arst_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {drv, pre, en, warn, shrt, hot, sk_q} = '0;
      {cool, gg} = 2'h3;
      {bad_count, comparisons, cycles, sinks} = '0;
      repeat (5) @(posedge mclk);
      arst_n <= 1'b1;
      test_apb;
      @(posedge mclk);
      en <= 1'b1;
      drv <= 1'b1;
      wait_c(0, 1'b1);
      test_oc;
      test_hs;
      test_latch;
      test_mode;
      test_therm;
      test_pre;
      print_verdict;
   end
endmodule : power_switch_fault_sequencer_test
`default_nettype wire
